// ===== bench/tsl_ee_model.sv
`timescale 1ns/10ps
module tsl_ee_model (
  // system clock times the write busy period
  input  wire logic clk_i,
  // serial pins seen from the memory
  input  wire logic cs_i,
  input  wire logic sk_i,
  input  wire logic di_i,
  output logic      do_o
);
  logic [7:0]  mem [0:127];
  logic [17:0] sh = 18'h0;
  logic [7:0]  rb = 8'h00;
  logic        rd = 1'b0;
  logic        wen = 1'b0;
  int          n = 0;
  int          busy = 0;
  int          slow = 0;  // busy cycles after a write, set by the bench
  // deselected line sits at its pull-up level
  assign do_o = !cs_i ? 1'b1 : rd ? rb[7] : (busy == 0);
  // each select starts a new command
  always @(posedge cs_i) begin
    n = 0;
    rd = 1'b0;
  end
  // command bits enter on the rising memory clock; writes need enable first
  always @(posedge sk_i) if (cs_i) begin
    sh = {sh[16:0], di_i};
    n = n + 1;
    if (n == 10 && sh[9:5] == 5'h13) wen = 1'b1;
    if (n == 10 && sh[9:7] == 3'h6) begin
      rd = 1'b1;
      rb = mem[sh[6:0]];
    end
    if (n == 18 && sh[17:15] == 3'h5 && wen) begin
      mem[sh[14:8]] = sh[7:0];
      busy = slow;
    end
  end
  // next data bit shows after the falling edge, so it is stable at the rise
  always @(negedge sk_i) if (rd && n > 10) rb = {rb[6:0], 1'b0};
  always @(posedge clk_i) if (busy > 0) busy = busy - 1;
endmodule // tsl_ee_model

// ===== bench/tsl_loader_asserts.sv
`timescale 1ns/10ps
module tsl_loader_asserts (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // apb handshake
  input wire logic       psel_i,
  input wire logic       penable_i,
  input wire logic       pready_o,
  input wire logic       pslverr_o,
  // straps and outputs
  input wire logic       standalone_i,
  input wire logic       eeprom_fitted_i,
  input wire logic [9:0] key_rep_o,
  input wire logic       comms_ready_out_o,
  input wire logic [9:0] key_drift_low_option_o,
  input wire logic       sync_acquire_enable_o,
  input wire logic       calibrating_o,
  input wire logic       acquire_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // no eeprom and no serial link: defaults differ
  wire bare = standalone_i && !eeprom_fitted_i;
  property p_bare_quiet; bare |-> !comms_ready_out_o; endproperty
  a_bare_quiet: assert property (p_bare_quiet)
    else $error("comms ready high without serial");
  property p_bare_drift; bare && acquire_en_o |-> key_drift_low_option_o == 10'h3FF; endproperty
  a_bare_drift: assert property (p_bare_drift)
    else $error("drift option not on all keys");
  property p_bare_sync; bare && acquire_en_o |-> sync_acquire_enable_o; endproperty
  a_bare_sync: assert property (p_bare_sync)
    else $error("sync acquire off in bare mode");
  property p_rep_run; key_rep_o != 10'h000 |-> acquire_en_o && !calibrating_o; endproperty
  a_rep_run: assert property (p_rep_run)
    else $error("key report outside run phase");
  property p_acq_hold; acquire_en_o |=> acquire_en_o; endproperty
  a_acq_hold: assert property (p_acq_hold)
    else $error("acquisition stopped");
  property p_cal_acq; calibrating_o |-> acquire_en_o; endproperty
  a_cal_acq: assert property (p_cal_acq)
    else $error("calibrating without acquisition");
  // setups are loaded before calibration can start
  property p_comms_load; $rose(calibrating_o) && !bare |-> comms_ready_out_o; endproperty
  a_comms_load: assert property (p_comms_load)
    else $error("comms not ready at calibration start");
  property p_rdy; psel_i && !penable_i ##1 psel_i && penable_i |=> pready_o; endproperty
  a_rdy: assert property (p_rdy)
    else $error("ready not in second access cycle");
  property p_rdy_pulse; pready_o |=> !pready_o; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("ready longer than one cycle");
  property p_err; pslverr_o |-> pready_o && psel_i && penable_i; endproperty
  a_err: assert property (p_err)
    else $error("error outside a transfer");
  c_cal_end: cover property ($fell(calibrating_o));
  c_err: cover property (pslverr_o);
  c_rep: cover property (key_rep_o != 10'h000);
endmodule // tsl_loader_asserts

bind tsl_loader tsl_loader_asserts u_chk (.clk_i, .rst_i, .psel_i, .penable_i, .pready_o,
  .pslverr_o, .standalone_i, .eeprom_fitted_i, .key_rep_o, .comms_ready_out_o,
  .key_drift_low_option_o, .sync_acquire_enable_o, .calibrating_o, .acquire_en_o);

// ===== bench/tsl_loader_tb_top.sv
`timescale 1ns/10ps
`include "tsl_params_params.svh"
module tsl_loader_tb_top;
  import tsl_pkg::*;
  localparam int MSC = 10;
  // design inputs
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic        standalone_i = 1'b0;
  logic        eeprom_fitted_i = 1'b0;
  logic [9:0]  key_det_i = 10'h000;
  logic [79:0] key_sig_i = 80'h0;
  // design outputs
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, ee_cs_o, ee_clk_o, ee_do_o, ee_din;
  logic [9:0]  key_rep_o, key_drift_low_option_o;
  logic        comms_ready_out_o, sync_acquire_enable_o, calibrating_o, acquire_en_o;
  // bench state and reference table
  int          fails = 0;
  int          checks_done = 0;
  int          w;
  logic [31:0] rs = 32'hCBDD;
  logic [31:0] q;
  logic        slverr;
  logic [7:0]  s0, s1;
  logic [7:0]  et [8];
  logic [7:0]  hb [8];

  tsl_loader #(.MS_CYCLES(MSC)) dut (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .standalone_i, .eeprom_fitted_i, .ee_cs_o,
    .ee_clk_o, .ee_do_o, .eeprom_serial_data_in_i(ee_din), .key_det_i, .key_sig_i, .key_rep_o,
    .comms_ready_out_o, .key_drift_low_option_o, .sync_acquire_enable_o, .calibrating_o,
    .acquire_en_o);
  tsl_ee_model u_ee (.clk_i, .cs_i(ee_cs_o), .sk_i(ee_clk_o), .di_i(ee_do_o), .do_o(ee_din));

  initial forever #20 clk_i = ~clk_i;

  function automatic logic [7:0] rnd();
    rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
    return rs[7:0];
  endfunction
  // crc-8, polynomial 07, msb first, over bytes 0..6
  function automatic logic [7:0] crc(input logic [7:0] b [8]);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 7; i++) begin
      c = c ^ b[i];
      for (int j = 0; j < 8; j++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask
  // one apb transfer; request held until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 9);
    q = prdata_o;
    slverr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (k >= 9) begin
      fails++;
      wrap_up();
    end
  endtask
  task automatic poll(input int b, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      apb(1'b0, `TSL_A_STATUS, 32'h0);
      n++;
    end while (q[b] !== v && n < lim);
    chk("status bit", {31'h0, v}, {31'h0, q[b]});
    if (q[b] !== v) wrap_up();
  endtask
  // reset, then time the start-up and calibration phases
  task automatic boot(input logic sa, input logic fit, input int sp);
    int t;
    int c;
    t = 0;
    c = 0;
    @(posedge clk_i);
    rst_i <= 1'b1;
    standalone_i <= sa;
    eeprom_fitted_i <= fit;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    while (calibrating_o !== 1'b1 && t < 20000) begin
      @(posedge clk_i);
      t++;
    end
    chk("init time", 1, t >= 400 * MSC && t < 20000);
    while (calibrating_o === 1'b1 && c < 20000) begin
      @(posedge clk_i);
      c++;
    end
    // calibration ends on a free-running millisecond tick: one tick either way
    chk("cal time", 1, c >= sp * 150 * MSC - MSC && c <= sp * 150 * MSC + MSC);
  endtask
  task automatic cfg(input logic sa, input int nb, input logic [31:0] st);
    chk("comms ready", !sa, comms_ready_out_o);
    chk("drift", sa ? 10'h3FF : {et[4][1:0], et[3]}, key_drift_low_option_o);
    chk("sync", sa | et[2][2], sync_acquire_enable_o);
    apb(1'b0, `TSL_A_STATUS, 32'h0);
    chk("status", st, q);
    for (int i = 0; i < nb; i++) begin
      apb(1'b1, `TSL_A_IDX, 32'(i));
      apb(1'b0, `TSL_A_DATA, 32'h0);
      chk("table", {24'h0, et[i]}, q);
    end
  endtask
  task automatic host(input logic bad);
    for (int i = 0; i < 7; i++) hb[i] = rnd();
    hb[0] = (rnd() & 8'h01) + 8'h01;
    hb[1] = 8'h03;
    hb[2] = hb[2] & 8'hFC;
    hb[7] = crc(hb) ^ {7'h0, bad};
    if (bad && hb[7] == `TSL_SIG) hb[7] = hb[7] ^ 8'h03;
    apb(1'b1, `TSL_A_IDX, 32'h0);
    for (int i = 0; i < 8; i++) apb(1'b1, `TSL_A_DATA, {24'h0, hb[i]});
    apb(1'b1, `TSL_A_COMMIT, 32'h1);
  endtask

  initial begin
    // bare standalone: defaults, drift and sync forced, no comms
    et = '{default: 8'h00};
    et[0] = `TSL_DEF_SPACING;
    boot(1'b1, 1'b0, 3);
    cfg(1'b1, 1, 32'h15);
    apb(1'b1, `TSL_A_CMD, `TSL_CMD_CLEAR);
    apb(1'b1, `TSL_A_CMD, `TSL_CMD_STATUS);
    apb(1'b1, `TSL_A_CMD, `TSL_CMD_CLEAR);
    apb(1'b0, `TSL_A_STATUS, 32'h0);
    chk("flag clear", 32'h14, q);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, slverr});
    chk("unmapped data", 32'h0, q);
    $display("test standalone finished");
    // valid random image, then corruption found by the periodic check
    for (int i = 0; i < 7; i++) et[i] = rnd();
    et[0] = (rnd() & 8'h01) + 8'h01;
    et[7] = crc(et);
    u_ee.mem[0] = `TSL_SIG;
    for (int i = 0; i < 8; i++) u_ee.mem[i + 1] = et[i];
    boot(1'b0, 1'b1, et[0]);
    cfg(1'b0, 8, 32'h95);
    u_ee.mem[8] = et[7] ^ 8'h01;
    poll(1, 1'b1, 7000);
    chk("no repair", {24'h0, et[7] ^ 8'h01}, {24'h0, u_ee.mem[8]});
    cfg(1'b0, 8, 32'h97);
    $display("test eeprom image finished");
    // blank memory: error and defaults, then host setups programme it
    for (int i = 0; i < 128; i++) u_ee.mem[i] = 8'hFF;
    u_ee.slow = 300;
    et = '{default: 8'h00};
    et[0] = `TSL_DEF_SPACING;
    boot(1'b0, 1'b1, 3);
    cfg(1'b0, 1, 32'h97);
    chk("blank kept", 32'hFF, {24'h0, u_ee.mem[0]});
    host(1'b1);
    poll(6, 1'b1, 20);
    cfg(1'b0, 1, 32'hD7);
    host(1'b0);
    et = hb;
    poll(5, 1'b1, 50);
    poll(5, 1'b0, 3000);
    chk("signature", {24'h0, `TSL_SIG}, {24'h0, u_ee.mem[0]});
    for (int i = 0; i < 8; i++) chk("stored", {24'h0, hb[i]}, {24'h0, u_ee.mem[i + 1]});
    // keys 0 and 1 grouped: only the stronger reports
    s0 = rnd();
    s1 = rnd();
    key_sig_i <= {56'h0, rnd(), s1, s0};
    key_det_i <= 10'h007;
    w = 0;
    while (key_rep_o === 10'h000 && w < 50) begin
      @(posedge clk_i);
      w++;
    end
    @(posedge clk_i);
    chk("reports", {7'h0, 1'b1, s1 > s0, s1 <= s0}, key_rep_o);
    key_det_i <= 10'h000;
    $display("test host setups finished");
    // stored image comes back at power-up, signature in crc place skips check
    u_ee.mem[8] = `TSL_SIG;
    et[7] = `TSL_SIG;
    boot(1'b0, 1'b1, et[0]);
    cfg(1'b0, 8, 32'h95);
    $display("test restore finished");
    wrap_up();
  end
endmodule // tsl_loader_tb_top

// ===== hdl/tsl_loader.sv
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "tsl_params_params.svh"
module tsl_loader #(
  parameter int MS_CYCLES = `TSL_CLK_HZ / 1000
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // straps
  input  wire logic        standalone_i,
  input  wire logic        eeprom_fitted_i,
  // serial eeprom
  output logic             ee_cs_o,
  output logic             ee_clk_o,
  output logic             ee_do_o,
  input  wire logic        eeprom_serial_data_in_i,
  // key path
  input  wire logic [9:0]  key_det_i,
  input  wire logic [79:0] key_sig_i,
  output logic      [9:0]  key_rep_o,
  // control outputs
  output logic             comms_ready_out_o,
  output logic      [9:0]  key_drift_low_option_o,
  output logic             sync_acquire_enable_o,
  output logic             calibrating_o,
  output logic             acquire_en_o
);
  import tsl_pkg::*;

  localparam int TW = 8 * `TSL_LEN;

  // one crc over the table bytes ahead of the crc byte
  function automatic logic [7:0] crc_tbl(input logic [TW-1:0] t);
    logic [7:0] c;
    c = 8'h00;
    for (int b = 0; b < `TSL_LEN - 1; b++) begin
      c = c ^ t[b*8 +: 8];
      for (int k = 0; k < 8; k++) begin
        c = c[7] ? ((c << 1) ^ `TSL_CRC_POLY) : (c << 1);
      end
    end
    return c;
  endfunction

  // image valid: crc byte equal to the signature skips the check
  function automatic logic tbl_ok(input logic [TW-1:0] t);
    logic [7:0] last;
    last = t[TW-8 +: 8];
    return (last == `TSL_SIG) || (last == crc_tbl(t));
  endfunction

  tsl_phase_t       phase_reg;
  tsl_job_t         job_reg;
  tsl_eng_t         eng_reg;
  logic [TW-1:0]    setup_reg, host_reg, eebuf_reg;
  logic [7:0]       sig_reg, idx_reg, rx_reg;
  logic [3:0]       addr_reg;
  logic             cap_reg, alone_reg, fit_reg;
  logic             loaded_reg, chk_reg, wr_pend_reg, due_reg;
  logic             rst_flag_reg, ee_err_reg, host_err_reg, arm_reg;
  logic [23:0]      tick_reg;
  logic [15:0]      ms_reg;
  logic [11:0]      rchk_reg;
  logic [3:0]       div_reg;
  logic [4:0]       cnt_reg;
  logic [17:0]      tx_reg;
  logic             wait_reg, done_reg;
  logic             go;
  logic [17:0]      go_word;
  logic [4:0]       go_len;
  logic             go_wait;

  // apb decode; pready is a flop so every transfer has one wait state
  wire        acc     = psel_i & penable_i;
  wire        fire    = acc & pready_o;
  wire        wr      = fire & pwrite_i;
  wire        a_st    = (paddr_i == `TSL_A_STATUS);
  wire        a_cmd   = (paddr_i == `TSL_A_CMD);
  wire        a_idx   = (paddr_i == `TSL_A_IDX);
  wire        a_dat   = (paddr_i == `TSL_A_DATA);
  wire        a_com   = (paddr_i == `TSL_A_COMMIT);
  wire        mapped  = a_st | a_cmd | a_idx | a_dat | a_com;
  wire [2:0]  bidx    = idx_reg[2:0];
  wire        host_ok = tbl_ok(host_reg);
  wire        commit  = wr & a_com;
  wire        nee     = alone_reg & ~fit_reg;
  wire [7:0]  status  = {fit_reg, host_err_reg, job_reg != J_IDLE, acquire_en_o,
                         calibrating_o, loaded_reg, ee_err_reg, rst_flag_reg};
  wire [31:0] rdata   = a_st  ? {24'h000000, status} :
                        a_idx ? {24'h000000, idx_reg} :
                        a_dat ? {24'h000000, setup_reg[bidx*8 +: 8]} : 32'h00000000;

  // apb answer flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= acc & ~pready_o;
      prdata_o  <= (acc & ~pready_o) ? rdata : prdata_o;
      pslverr_o <= acc & ~pready_o & ~mapped;
    end
  end

  // host side registers: index, setups buffer, status command pair
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_reg      <= 8'h00;
      host_reg     <= '0;
      arm_reg      <= 1'b0;
      rst_flag_reg <= 1'b1;
      host_err_reg <= 1'b0;
    end else begin
      if (wr & a_idx) begin
        idx_reg <= pwdata_i[7:0];
      end
      if (wr & a_dat) begin
        host_reg[bidx*8 +: 8] <= pwdata_i[7:0];
        idx_reg               <= idx_reg + 8'h01;
      end
      if (wr & a_cmd) begin
        arm_reg <= (pwdata_i[7:0] == `TSL_CMD_STATUS);
      end
      if (wr & a_cmd & arm_reg & (pwdata_i[7:0] == `TSL_CMD_CLEAR)) begin
        rst_flag_reg <= 1'b0;
        host_err_reg <= 1'b0;
      end
      if (commit & ~host_ok) begin
        host_err_reg <= 1'b1;
      end
    end
  end

  // straps are caught on the first edge after reset release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_reg   <= 1'b0;
      alone_reg <= 1'b0;
      fit_reg   <= 1'b0;
    end else if (!cap_reg) begin
      cap_reg   <= 1'b1;
      alone_reg <= standalone_i;
      fit_reg   <= eeprom_fitted_i;
    end
  end

  // millisecond tick, phase timer and recheck timer
  wire        ms_tick = (tick_reg == 24'(MS_CYCLES - 1));
  wire [15:0] cal_ms  = 16'(setup_reg[`TSL_B_SPACING*8 +: 8] * (`TSL_CAL_MS / `TSL_CAL_SPACE_MS));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_reg  <= 24'h000000;
      ms_reg    <= 16'h0000;
      rchk_reg  <= 12'h000;
      phase_reg <= P_INIT;
      due_reg   <= 1'b0;
    end else begin
      tick_reg <= ms_tick ? 24'h000000 : tick_reg + 24'h000001;
      if (ms_tick) begin
        ms_reg <= ms_reg + 16'h0001;
      end
      unique case (phase_reg)
        P_INIT: if (loaded_reg && ms_reg >= 16'(`TSL_INIT_MS)) begin
          phase_reg <= P_CAL;
          ms_reg    <= 16'h0000;
        end
        P_CAL: if (ms_reg >= cal_ms) begin
          phase_reg <= P_RUN;
        end
        P_RUN: if (ms_tick) begin
          // the check may wait behind an eeprom write, so it is latched
          rchk_reg <= (rchk_reg == 12'(`TSL_RECHECK_MS - 1)) ? 12'h000 : rchk_reg + 12'h001;
          if (rchk_reg == 12'(`TSL_RECHECK_MS - 1)) begin
            due_reg <= fit_reg; // nothing to recheck without a memory
          end
        end
      endcase
      if (job_reg == J_IDLE && due_reg && !wr_pend_reg) begin
        due_reg <= 1'b0;
      end
    end
  end

  // eeprom job sequencer: load, periodic check, host image write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      job_reg     <= J_IDLE;
      setup_reg   <= '0;
      eebuf_reg   <= '0;
      sig_reg     <= 8'h00;
      addr_reg    <= 4'h0;
      loaded_reg  <= 1'b0;
      chk_reg     <= 1'b0;
      ee_err_reg  <= 1'b0;
      wr_pend_reg <= 1'b0;
    end else begin
      if (commit & host_ok) begin
        setup_reg <= host_reg;
        if (fit_reg) begin
          wr_pend_reg <= 1'b1;
        end
      end
      unique case (job_reg)
        J_IDLE: if (cap_reg) begin
          if (!loaded_reg && !fit_reg) begin
            setup_reg               <= '0;
            setup_reg[7:0]          <= `TSL_DEF_SPACING;
            loaded_reg              <= 1'b1;
          end else if (!loaded_reg || (due_reg && !wr_pend_reg)) begin
            chk_reg  <= loaded_reg;
            addr_reg <= 4'h0;
            job_reg  <= J_RD;
          end else if (wr_pend_reg && !(commit & host_ok)) begin
            wr_pend_reg <= 1'b0;
            job_reg     <= J_EWEN;
          end
        end
        J_RD: job_reg <= J_RDW;
        J_RDW: if (done_reg) begin
          if (addr_reg == 4'h0) begin
            sig_reg <= rx_reg;
          end else begin
            eebuf_reg[(addr_reg - 4'h1)*8 +: 8] <= rx_reg;
          end
          addr_reg <= addr_reg + 4'h1;
          job_reg  <= (addr_reg == 4'(`TSL_LEN)) ? J_EVAL : J_RD;
        end
        J_EVAL: begin
          job_reg <= J_IDLE;
          if (sig_reg != `TSL_SIG || !tbl_ok(eebuf_reg)) begin
            ee_err_reg <= 1'b1;
            if (!chk_reg) begin
              setup_reg      <= '0;
              setup_reg[7:0] <= `TSL_DEF_SPACING;
            end
          end else if (!chk_reg) begin
            setup_reg <= eebuf_reg;
          end
          loaded_reg <= 1'b1;
        end
        J_EWEN: job_reg <= J_EWW;
        J_EWW: if (done_reg) begin
          addr_reg <= 4'h0;
          job_reg  <= J_WR;
        end
        J_WR: job_reg <= J_WRW;
        J_WRW: if (done_reg) begin
          addr_reg <= addr_reg + 4'h1;
          job_reg  <= (addr_reg == 4'(`TSL_LEN)) ? J_IDLE : J_WR;
        end
      endcase
    end
  end

  // engine requests: signature at address zero, table after it
  wire [7:0] wr_byte = (addr_reg == 4'h0) ? `TSL_SIG : host_reg[(addr_reg - 4'h1)*8 +: 8];
  assign go      = (job_reg == J_RD) | (job_reg == J_EWEN) | (job_reg == J_WR);
  assign go_word = (job_reg == J_RD)   ? {`TSL_OP_RD, 3'h0, addr_reg, 8'h00} :
                   (job_reg == J_EWEN) ? {`TSL_OP_EWEN, 8'h00} :
                   {`TSL_OP_WR, 3'h0, addr_reg, wr_byte};
  assign go_len  = (job_reg == J_EWEN) ? `TSL_EE_LEN_EWEN : `TSL_EE_LEN_RW;
  assign go_wait = (job_reg == J_WR);

  // serial engine: data out changes on the falling clock, in on the rising
  wire ee_tick = (div_reg == 4'(`TSL_EE_DIV - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eng_reg  <= E_IDLE;
      div_reg  <= 4'h0;
      cnt_reg  <= 5'h00;
      tx_reg   <= 18'h00000;
      rx_reg   <= 8'h00;
      wait_reg <= 1'b0;
      done_reg <= 1'b0;
      ee_cs_o  <= 1'b0;
      ee_clk_o <= 1'b0;
      ee_do_o  <= 1'b0;
    end else begin
      div_reg  <= ee_tick ? 4'h0 : div_reg + 4'h1;
      done_reg <= 1'b0;
      unique case (eng_reg)
        E_IDLE: if (go) begin
          eng_reg  <= E_SHIFT;
          tx_reg   <= go_word;
          ee_do_o  <= go_word[17];
          cnt_reg  <= go_len;
          wait_reg <= go_wait;
          ee_cs_o  <= 1'b1;
        end
        E_SHIFT: if (ee_tick) begin
          ee_clk_o <= ~ee_clk_o;
          if (!ee_clk_o) begin
            rx_reg <= {rx_reg[6:0], eeprom_serial_data_in_i};
          end else begin
            tx_reg  <= {tx_reg[16:0], 1'b0};
            ee_do_o <= tx_reg[16];
            cnt_reg <= cnt_reg - 5'h01;
            if (cnt_reg == 5'h01) begin
              eng_reg <= E_GAP;
            end
          end
        end
        E_GAP: if (ee_tick) begin
          ee_cs_o <= 1'b0;
          ee_do_o <= 1'b0;
          eng_reg <= wait_reg ? E_BUSY : E_IDLE;
          done_reg <= !wait_reg;
        end
        E_BUSY: if (ee_tick) begin
          // high data-in while selected marks the write as finished
          ee_cs_o <= 1'b1;
          if (ee_cs_o && eeprom_serial_data_in_i) begin
            ee_cs_o  <= 1'b0;
            eng_reg  <= E_IDLE;
            done_reg <= 1'b1;
          end
        end
      endcase
    end
  end

  // adjacent group: only the strongest detecting member reports
  logic [9:0] grp_mask, rep;
  logic [7:0] best;
  logic [3:0] win;
  logic       any;
  always_comb begin
    grp_mask = {setup_reg[`TSL_B_CTRL*8 +: 2], setup_reg[`TSL_B_GROUP_LO*8 +: 8]};
    best     = 8'h00;
    win      = 4'h0;
    any      = 1'b0;
    for (int i = 0; i < 10; i++) begin
      if (grp_mask[i] && key_det_i[i] && (!any || key_sig_i[i*8 +: 8] > best)) begin
        best = key_sig_i[i*8 +: 8];
        win  = 4'(i);
        any  = 1'b1;
      end
    end
    rep = key_det_i & ~grp_mask;
    if (any) begin
      rep[win] = 1'b1;
    end
  end

  // control outputs; standalone without eeprom forces its own defaults
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_rep_o              <= 10'h000;
      comms_ready_out_o      <= 1'b0;
      key_drift_low_option_o <= 10'h000;
      sync_acquire_enable_o  <= 1'b0;
      calibrating_o          <= 1'b0;
      acquire_en_o           <= 1'b0;
    end else begin
      key_rep_o              <= (phase_reg == P_RUN) ? rep : 10'h000;
      comms_ready_out_o      <= loaded_reg & ~nee;
      key_drift_low_option_o <= nee ? 10'h3FF :
        {setup_reg[`TSL_B_DRIFT_HI*8 +: 2], setup_reg[`TSL_B_DRIFT_LO*8 +: 8]};
      sync_acquire_enable_o  <= nee | setup_reg[`TSL_B_CTRL*8 + `TSL_CTRL_SYNC];
      calibrating_o          <= (phase_reg == P_CAL);
      acquire_en_o           <= (phase_reg != P_INIT);
    end
  end

endmodule // tsl_loader

// ===== inc/tsl_params_params.svh
`ifndef TSL_PARAMS_PARAMS_SVH
`define TSL_PARAMS_PARAMS_SVH
// clock and timing, times in their own units
`define TSL_CLK_HZ        25000000
`define TSL_INIT_MS       400
`define TSL_CAL_MS        450
`define TSL_CAL_SPACE_MS  3
`define TSL_RECHECK_MS    2000
`define TSL_EE_DIV        16
// setups image
`define TSL_SIG           8'hD6
`define TSL_LEN           8
`define TSL_CRC_POLY      8'h07
`define TSL_DEF_SPACING   8'h03
`define TSL_DEF_ZERO      8'h00
// table byte positions
`define TSL_B_SPACING     0
`define TSL_B_GROUP_LO    1
`define TSL_B_CTRL        2
`define TSL_B_DRIFT_LO    3
`define TSL_B_DRIFT_HI    4
`define TSL_CTRL_SYNC     2
// eeprom opcodes, start bit first
`define TSL_OP_RD         3'h6
`define TSL_OP_WR         3'h5
`define TSL_OP_EWEN       10'h260
`define TSL_EE_LEN_RW     5'h12
`define TSL_EE_LEN_EWEN   5'h0A
// apb byte offsets
`define TSL_A_STATUS      8'h00
`define TSL_A_CMD         8'h04
`define TSL_A_IDX         8'h08
`define TSL_A_DATA        8'h0C
`define TSL_A_COMMIT      8'h10
// host command codes
`define TSL_CMD_STATUS    8'hC2
`define TSL_CMD_CLEAR     8'hC7
`endif

// ===== inc/tsl_pkg.sv
package tsl_pkg;
  typedef enum logic [1:0] {P_INIT, P_CAL, P_RUN} tsl_phase_t;
  typedef enum logic [2:0] {J_IDLE, J_RD, J_RDW, J_EVAL, J_EWEN, J_EWW, J_WR, J_WRW} tsl_job_t;
  typedef enum logic [1:0] {E_IDLE, E_SHIFT, E_GAP, E_BUSY} tsl_eng_t;
endpackage
